// [core/iocp_pkg.sv]
// Package with register map, field positions and reset values for the io and power control block
// Overview of operation
// - ROM select with program write enable forces address fifteen low on external access.
// - High bit-io enable connects bit-io four to seven, removes vector outputs.
// - Program write enable permits external program memory data writes, else blocked.
// - Second serial enable routes serial two and low bit-io, disconnects host port.
// - Loopback feeds each serial data output back to its serial data input.
// - Three-bit clock output select picks free, waited, high, low, raw, sequenced.
// - Clock phase aligns to the rising edge of reset release.
// - Slow clock select makes free and waited outputs follow the ring oscillator.
// - Waited clock follows instruction cycle stretched by the space wait count.
// - Plain waited clock completes one half cycle per sequenced external access.
// - Sequenced waited clock completes two stretched halves, one whole cycle, per sequenced access.
// - Crystal off powers down the small-signal clock input.
// - Slow clock bit switches internal clock source to the ring oscillator.
// - Clock stop halts the processor clock until the bit clears.
// - With wake enable zero, interrupt zero clears clock stop.
// - With wake enable one, interrupt one clears clock stop.
// - Wait-state register resets to ones if memory select high, interrupt one low.
// - Every register bit is reloaded with a defined value at each reset.
// - Pin-valued bits reflect the input pin level after reset.
// - Each four-bit wait field holds the count for one external space.
package iocp_pkg;
    localparam logic [3:0] IOCP_ADDR_IO_CFG = 4'h0;
    localparam logic [3:0] IOCP_ADDR_PWR_CTL = 4'h4;
    localparam logic [3:0] IOCP_ADDR_WAIT = 4'h8;
    localparam logic [3:0] IOCP_ADDR_STATUS = 4'hC;
    localparam logic [15:0] IOCP_IO_CFG_RST = 16'h0000;
    localparam logic [15:0] IOCP_PWR_CTL_RST = 16'h0000;
    localparam logic [15:0] IOCP_WAIT_ONES = 16'hFFFF;
    localparam logic [15:0] IOCP_WAIT_ZEROS = 16'h0000;
    // Writable bits; reserved ones read as zero
    localparam logic [15:0] IOCP_IO_CFG_MASK = 16'h7F8F;
    localparam logic [15:0] IOCP_PWR_CTL_MASK = 16'hF4F1;
    localparam int IOCP_EXTERNAL_ROM_SELECT_BIT = 14;
    localparam int IOCP_CKO_HI_BIT = 13;
    localparam int IOCP_HIGH_BIT_IO_ENABLE_BIT = 12;
    localparam int IOCP_PROGRAM_MEMORY_WRITE_ENABLE_BIT = 11;
    localparam int IOCP_SECOND_SERIAL_ENABLE_BIT = 10;
    localparam int IOCP_LOOP_BIT = 9;
    localparam int IOCP_CKO_LO_POS = 7;
    localparam int IOCP_XTAL_BIT = 15;
    localparam int IOCP_SLOW_BIT = 14;
    localparam int IOCP_STOP_BIT = 13;
    localparam int IOCP_W0_BIT = 12;
    localparam int IOCP_W1_BIT = 10;
    localparam int IOCP_SIO1_BIT = 7;
    localparam int IOCP_SECOND_SERIAL_PORT_BIT = 6;
    localparam int IOCP_HOST_BIT = 5;
    localparam int IOCP_TMR_BIT = 4;
    localparam int IOCP_EMU_BIT = 0;
    localparam logic [1:0] IOCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] IOCP_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        IOCP_CKO_FREE = 3'h0,
        IOCP_CKO_WAIT = 3'h1,
        IOCP_CKO_HIGH = 3'h2,
        IOCP_CKO_LOW = 3'h3,
        IOCP_CKO_RAW = 3'h4,
        IOCP_CKO_SEQ = 3'h5
    } iocp_cko_e;

    // Side-band from the core's memory interface
    typedef struct packed {
        logic access;
        logic seq;
        logic prog_space;
        logic data_write;
        logic [1:0] space;
        logic addr15;
    } iocp_mem_s;

    // Shared pin routing outputs
    typedef struct packed {
        logic second_serial_port_on;
        logic host_on;
        logic bio_low_on;
        logic bio_high_on;
        logic vec_on;
    } iocp_pins_s;

    // Wait-state counter FSM, one-hot
    typedef enum logic [2:0] {
        IOCP_WS_IDLE = 3'b001,
        IOCP_WS_HALF = 3'b010,
        IOCP_WS_STRETCH = 3'b100
    } iocp_ws_e;
endpackage : iocp_pkg

// [core/iocp_top.sv]
// Io configuration and power control registers with clock output and pin routing
`timescale 1ns/1ps
module iocp_top
    import iocp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    // AXI4-Lite slave
    input wire logic [3:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [3:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    // Pins and core events
    input wire logic EXT_MEM_SEL_IN,
    input wire logic IRQ_ZERO_IN,
    input wire logic IRQ_ONE_IN,
    input wire logic RING_OSC_TICK_IN,
    input wire logic CLOCK_INPUT_IN,
    input wire logic INSTR_CYCLE_IN,
    input wire iocp_mem_s MEM_IN,
    // Serial data
    input wire logic [1:0] SERIAL_DATA_OUT_IN,
    input wire logic [1:0] SERIAL_DATA_PIN_IN,
    output logic [1:0] SERIAL_DATA_IN_OUT,
    // Controls to the rest of the core
    output logic ADDR_LINE_FIFTEEN_OUT,
    output logic PROG_WRITE_ALLOW_OUT,
    output iocp_pins_s PINS_OUT,
    output logic CLOCK_OUTPUT_OUT,
    output logic CRYSTAL_OFF_OUT,
    output logic SLOW_CLOCK_OUT,
    output logic CORE_CLK_EN_OUT,
    output logic [3:0] DELAY_EN_OUT,
    output logic [4:0] PERIPH_DISABLE_OUT,
    output logic [15:0] WAIT_STATES_OUT
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [15:0] io_cfg_q;
    logic [15:0] pwr_ctl_q;
    logic [15:0] wait_q;
    logic strap_pend_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [15:0] wr_word;
    logic wr_hit;
    logic [15:0] rd_word;
    logic rd_hit;
    logic [2:0] cko_sel;
    logic [3:0] ws_count;
    logic free_phase_q;
    logic wait_phase_q;
    logic seq_phase_q;
    logic [3:0] ws_cnt_q;
    logic [1:0] seq_left_q;
    iocp_ws_e ws_state_q;
    logic src_tick;
    logic wake;

    // Reset release through two flops
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // AXI write channel: address and data may come in either order
    // A pending response blocks both channels, so one write at most is in flight
    assign AWREADY_OUT = !aw_hold_q && !bvalid_q;
    assign WREADY_OUT = !w_hold_q && !bvalid_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    // Only the two low strobes count; the upper lanes carry nothing here
    assign wr_word = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
    assign wr_hit = (awaddr_q == IOCP_ADDR_IO_CFG) || (awaddr_q == IOCP_ADDR_PWR_CTL)
        || (awaddr_q == IOCP_ADDR_WAIT);

    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= IOCP_RESP_OKAY;
        end
        else
        begin
            if (AWVALID_IN && AWREADY_OUT)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= {AWADDR_IN[3:2], 2'h0};
            end
            if (WVALID_IN && WREADY_OUT)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= WDATA_IN;
                wstrb_q <= WSTRB_IN;
            end
            if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? IOCP_RESP_OKAY : IOCP_RESP_SLVERR;
            end
            else if (bvalid_q && BREADY_IN)
                bvalid_q <= 1'b0;
        end
    end
    assign BVALID_OUT = bvalid_q;
    assign BRESP_OUT = bresp_q;

    // Byte-lane partial writes keep untouched bytes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
        input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] r;
        r = old;
        if (strb[0])
            r[7:0] = nw[7:0];
        if (strb[1])
            r[15:8] = nw[15:8];
        return r & mask;
    endfunction : merge

    // Pin configuration register
    // Every bit of both registers has a defined reset value; none is left undefined
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            io_cfg_q <= IOCP_IO_CFG_RST;
        else if (wr_fire && awaddr_q == IOCP_ADDR_IO_CFG)
            io_cfg_q <= merge(io_cfg_q, wr_word, wstrb_q, IOCP_IO_CFG_MASK);
    end

    // Power control; a wake interrupt beats a simultaneous software write of the stop bit
    assign wake = (pwr_ctl_q[IOCP_W0_BIT] && IRQ_ZERO_IN)
        || (pwr_ctl_q[IOCP_W1_BIT] && IRQ_ONE_IN);
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            pwr_ctl_q <= IOCP_PWR_CTL_RST;
        else
        begin
            // Reserved bits are dropped by the mask whatever software writes
            if (wr_fire && awaddr_q == IOCP_ADDR_PWR_CTL)
                pwr_ctl_q <= merge(pwr_ctl_q, wr_word, wstrb_q, IOCP_PWR_CTL_MASK);
            if (wake)
            begin
                pwr_ctl_q[IOCP_STOP_BIT] <= 1'b0;
            end
        end
    end

    // Wait-state register, strapped from pins on the first edge after release
    // Pins must hold their levels until the third edge after the reset pin rises
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q <= IOCP_WAIT_ZEROS;
            strap_pend_q <= 1'b1;
        end
        else if (strap_pend_q)
        begin
            strap_pend_q <= 1'b0;
            // Pin levels sampled at release
            wait_q <= (EXT_MEM_SEL_IN && !IRQ_ONE_IN) ? IOCP_WAIT_ONES : IOCP_WAIT_ZEROS;
        end
        else if (wr_fire && awaddr_q == IOCP_ADDR_WAIT)
            wait_q <= merge(wait_q, wr_word, wstrb_q, 16'hFFFF);
    end

    // AXI read channel
    // Status word is read only; a write to it is answered with an error
    assign ARREADY_OUT = !rvalid_q;
    always_comb
    begin
        rd_hit = 1'b1;
        case ({ARADDR_IN[3:2], 2'h0})
            IOCP_ADDR_IO_CFG: rd_word = io_cfg_q;
            IOCP_ADDR_PWR_CTL: rd_word = pwr_ctl_q;
            IOCP_ADDR_WAIT: rd_word = wait_q;
            IOCP_ADDR_STATUS: rd_word = {11'h000, ws_state_q != IOCP_WS_IDLE, seq_phase_q,
                wait_phase_q, free_phase_q, CLOCK_OUTPUT_OUT};
            default:
            begin
                rd_word = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= IOCP_RESP_OKAY;
        end
        else if (ARVALID_IN && ARREADY_OUT)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? IOCP_RESP_OKAY : IOCP_RESP_SLVERR;
        end
        else if (rvalid_q && RREADY_IN)
            rvalid_q <= 1'b0;
    end
    assign RVALID_OUT = rvalid_q;
    assign RDATA_OUT = rdata_q;
    assign RRESP_OUT = rresp_q;

    // Memory and pin routing controls
    assign ADDR_LINE_FIFTEEN_OUT = (io_cfg_q[IOCP_EXTERNAL_ROM_SELECT_BIT] && io_cfg_q[IOCP_PROGRAM_MEMORY_WRITE_ENABLE_BIT]
        && MEM_IN.access) ? 1'b0 : MEM_IN.addr15;
    assign PROG_WRITE_ALLOW_OUT = io_cfg_q[IOCP_PROGRAM_MEMORY_WRITE_ENABLE_BIT]
        || !(MEM_IN.prog_space && MEM_IN.data_write);
    assign PINS_OUT.bio_high_on = io_cfg_q[IOCP_HIGH_BIT_IO_ENABLE_BIT];
    assign PINS_OUT.vec_on = !io_cfg_q[IOCP_HIGH_BIT_IO_ENABLE_BIT];
    assign PINS_OUT.second_serial_port_on = io_cfg_q[IOCP_SECOND_SERIAL_ENABLE_BIT];
    assign PINS_OUT.bio_low_on = io_cfg_q[IOCP_SECOND_SERIAL_ENABLE_BIT];
    assign PINS_OUT.host_on = !io_cfg_q[IOCP_SECOND_SERIAL_ENABLE_BIT];
    // Loopback takes the pins out of the path for both ports at once
    assign SERIAL_DATA_IN_OUT = io_cfg_q[IOCP_LOOP_BIT] ? SERIAL_DATA_OUT_IN
        : SERIAL_DATA_PIN_IN;
    assign DELAY_EN_OUT = io_cfg_q[3:0];
    assign PERIPH_DISABLE_OUT = {pwr_ctl_q[IOCP_SIO1_BIT], pwr_ctl_q[IOCP_SECOND_SERIAL_PORT_BIT],
        pwr_ctl_q[IOCP_HOST_BIT], pwr_ctl_q[IOCP_TMR_BIT], pwr_ctl_q[IOCP_EMU_BIT]};
    assign WAIT_STATES_OUT = wait_q;
    assign CRYSTAL_OFF_OUT = pwr_ctl_q[IOCP_XTAL_BIT];
    assign SLOW_CLOCK_OUT = pwr_ctl_q[IOCP_SLOW_BIT];
    // Held off until the internal release so the core starts on a whole cycle
    assign CORE_CLK_EN_OUT = !pwr_ctl_q[IOCP_STOP_BIT] && rst_n;

    // Clock output generation
    assign cko_sel = {io_cfg_q[IOCP_CKO_HI_BIT], io_cfg_q[IOCP_CKO_LO_POS +: 2]};
    assign ws_count = wait_q[{MEM_IN.space, 2'b00} +: 4];
    // Source tick picks ring oscillator when slow clock is on
    assign src_tick = pwr_ctl_q[IOCP_SLOW_BIT] ? RING_OSC_TICK_IN : INSTR_CYCLE_IN;

    // Phases start from zero at reset release, giving a defined phase
    // Free clock toggles once per source tick, so it runs at half the tick rate
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            free_phase_q <= 1'b0;
        else if (src_tick)
            free_phase_q <= !free_phase_q;
    end

    // Waited clock: one half per tick, each half stretched by the space count
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ws_state_q <= IOCP_WS_IDLE;
            ws_cnt_q <= 4'h0;
            wait_phase_q <= 1'b0;
            seq_phase_q <= 1'b0;
            seq_left_q <= 2'h0;
        end
        else
        begin
            case (ws_state_q)
                IOCP_WS_IDLE:
                    if (src_tick)
                    begin
                        ws_cnt_q <= MEM_IN.access ? ws_count : 4'h0;
                        // Sequenced access: two halves for the sequenced output
                        seq_left_q <= (MEM_IN.access && MEM_IN.seq) ? 2'h3 : 2'h1;
                        ws_state_q <= IOCP_WS_STRETCH;
                    end
                IOCP_WS_STRETCH:
                    if (ws_cnt_q == 4'h0)
                    begin
                        // The extra sequenced half must not move the plain waited clock
                        if (seq_left_q != 2'h2)
                        begin
                            wait_phase_q <= !wait_phase_q;
                        end
                        seq_phase_q <= !seq_phase_q;
                        ws_state_q <= IOCP_WS_HALF;
                    end
                    else
                    begin
                        ws_cnt_q <= ws_cnt_q - 4'h1;
                    end
                IOCP_WS_HALF:
                    if (seq_left_q == 2'h3)
                    begin
                        // Second sequenced half, stretched by the same space count
                        seq_left_q <= 2'h2;
                        ws_cnt_q <= ws_count;
                        ws_state_q <= IOCP_WS_STRETCH;
                    end
                    else
                    begin
                        ws_state_q <= IOCP_WS_IDLE;
                    end
                default:
                    ws_state_q <= IOCP_WS_IDLE;
            endcase
        end
    end

    always_comb
    begin
        case (cko_sel)
            // A select change takes effect at once and may cut a phase short
            IOCP_CKO_FREE: CLOCK_OUTPUT_OUT = free_phase_q;
            IOCP_CKO_WAIT: CLOCK_OUTPUT_OUT = wait_phase_q;
            IOCP_CKO_HIGH: CLOCK_OUTPUT_OUT = 1'b1;
            IOCP_CKO_LOW: CLOCK_OUTPUT_OUT = 1'b0;
            IOCP_CKO_RAW: CLOCK_OUTPUT_OUT = CLOCK_INPUT_IN;
            IOCP_CKO_SEQ: CLOCK_OUTPUT_OUT = seq_phase_q;
            // Reserved codes hold low
            default: CLOCK_OUTPUT_OUT = 1'b0;
        endcase
    end
endmodule : iocp_top

// [verif/iocp_top_monitor.sv]
// Port-level checker for the io and power control block
`timescale 1ns/1ps
module iocp_top_monitor
    import iocp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    // Register bus
    input wire logic AWVALID_IN,
    input wire logic AWREADY_OUT,
    input wire logic WVALID_IN,
    input wire logic WREADY_OUT,
    input wire logic [1:0] BRESP_OUT,
    input wire logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic ARVALID_IN,
    input wire logic ARREADY_OUT,
    input wire logic [31:0] RDATA_OUT,
    input wire logic RVALID_OUT,
    input wire logic RREADY_IN,
    // Pins
    input wire iocp_mem_s MEM_IN,
    input wire logic ADDR_LINE_FIFTEEN_OUT,
    input wire iocp_pins_s PINS_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    sequence s_wr_taken;
        AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
    endsequence
    sequence s_rd_taken;
        ARVALID_IN && ARREADY_OUT;
    endsequence

    // The block may only pull the line low, never raise it
    a_addr_low_only: assert property (
        MEM_IN.access && ADDR_LINE_FIFTEEN_OUT |-> MEM_IN.addr15)
        else $error("address line fifteen raised");
    a_bio_vec_swap: assert property (
        PINS_OUT.bio_high_on != PINS_OUT.vec_on)
        else $error("bit io high half and vectors share pins");
    a_sio_host_swap: assert property (
        PINS_OUT.second_serial_port_on == PINS_OUT.bio_low_on && PINS_OUT.host_on != PINS_OUT.second_serial_port_on)
        else $error("serial two and host port routing clash");
    a_wr_answer: assert property (s_wr_taken |-> ##[1:2] BVALID_OUT)
        else $error("write response missing");
    a_bresp_hold: assert property (
        BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response dropped");
    a_wr_blocked: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
        else $error("write taken while response pending");
    a_rd_answer: assert property (s_rd_taken |=> RVALID_OUT)
        else $error("read data missing");
    a_rdata_hold: assert property (
        RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("read data dropped");
    a_rd_blocked: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read taken while data pending");
    a_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
endmodule : iocp_top_monitor

// [verif/iocp_top_test.sv]
// Self-checking bench for the io and power control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module iocp_top_test
    import iocp_pkg::*;
;
    logic MCLK_IN = 1'b0;
    logic ARST_N_IN = 1'b0;
    logic [3:0] AWADDR_IN = '0, ARADDR_IN = '0, WSTRB_IN = '0;
    logic AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0;
    logic ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
    logic [31:0] WDATA_IN = '0;
    logic EXT_MEM_SEL_IN = 1'b1, IRQ_ZERO_IN = 1'b0, IRQ_ONE_IN = 1'b0;
    logic RING_OSC_TICK_IN = 1'b0, CLOCK_INPUT_IN = 1'b0, INSTR_CYCLE_IN = 1'b0;
    iocp_mem_s MEM_IN = '0;
    logic [1:0] SERIAL_DATA_OUT_IN = '0, SERIAL_DATA_PIN_IN = '0;
    logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
    logic ADDR_LINE_FIFTEEN_OUT, PROG_WRITE_ALLOW_OUT, CLOCK_OUTPUT_OUT;
    logic CRYSTAL_OFF_OUT, SLOW_CLOCK_OUT, CORE_CLK_EN_OUT;
    logic [1:0] BRESP_OUT, RRESP_OUT, SERIAL_DATA_IN_OUT;
    logic [31:0] RDATA_OUT;
    iocp_pins_s PINS_OUT;
    logic [3:0] DELAY_EN_OUT;
    logic [4:0] PERIPH_DISABLE_OUT;
    logic [15:0] WAIT_STATES_OUT;
    logic [15:0] mdl [0:2];
    int errors = 0;
    int compares = 0;

    iocp_top u_dut (
        .MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .AWADDR_IN(AWADDR_IN),
        .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN),
        .WSTRB_IN(WSTRB_IN), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
        .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
        .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
        .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT),
        .RREADY_IN(RREADY_IN), .EXT_MEM_SEL_IN(EXT_MEM_SEL_IN), .IRQ_ZERO_IN(IRQ_ZERO_IN),
        .IRQ_ONE_IN(IRQ_ONE_IN), .RING_OSC_TICK_IN(RING_OSC_TICK_IN),
        .CLOCK_INPUT_IN(CLOCK_INPUT_IN), .INSTR_CYCLE_IN(INSTR_CYCLE_IN), .MEM_IN(MEM_IN),
        .SERIAL_DATA_OUT_IN(SERIAL_DATA_OUT_IN), .SERIAL_DATA_PIN_IN(SERIAL_DATA_PIN_IN),
        .SERIAL_DATA_IN_OUT(SERIAL_DATA_IN_OUT), .ADDR_LINE_FIFTEEN_OUT(ADDR_LINE_FIFTEEN_OUT),
        .PROG_WRITE_ALLOW_OUT(PROG_WRITE_ALLOW_OUT), .PINS_OUT(PINS_OUT),
        .CLOCK_OUTPUT_OUT(CLOCK_OUTPUT_OUT), .CRYSTAL_OFF_OUT(CRYSTAL_OFF_OUT),
        .SLOW_CLOCK_OUT(SLOW_CLOCK_OUT), .CORE_CLK_EN_OUT(CORE_CLK_EN_OUT),
        .DELAY_EN_OUT(DELAY_EN_OUT), .PERIPH_DISABLE_OUT(PERIPH_DISABLE_OUT),
        .WAIT_STATES_OUT(WAIT_STATES_OUT)
    );

    always #2.5 MCLK_IN = ~MCLK_IN;

    function automatic logic [15:0] wmask(input logic [1:0] i);
        return (i == 2'd0) ? IOCP_IO_CFG_MASK : (i == 2'd1) ? IOCP_PWR_CTL_MASK : 16'hFFFF;
    endfunction : wmask

    task automatic give_verdict();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // One bus transfer; ready is held back dly cycles to exercise the hold rules
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
        input logic [1:0] s, input int dly);
        int n;
        logic [15:0] be;
        n = 0;
        be = {{8{s[1]}}, {8{s[0]}}};
        @(posedge MCLK_IN);
        AWADDR_IN <= a;
        ARADDR_IN <= a;
        WDATA_IN <= {16'h0000, d};
        WSTRB_IN <= {2'b00, s};
        {AWVALID_IN, WVALID_IN, ARVALID_IN} <= {w, w, !w};
        {BREADY_IN, RREADY_IN} <= (dly == 0) ? {w, !w} : 2'b00;
        forever
        begin
            @(posedge MCLK_IN);
            if ((BVALID_OUT && BREADY_IN) || (RVALID_OUT && RREADY_IN))
                break;
            n++;
            if (AWVALID_IN && AWREADY_OUT) AWVALID_IN <= 1'b0;
            if (WVALID_IN && WREADY_OUT) WVALID_IN <= 1'b0;
            if (ARVALID_IN && ARREADY_OUT) ARVALID_IN <= 1'b0;
            if (n >= dly) {BREADY_IN, RREADY_IN} <= {w, !w};
        end
        {BREADY_IN, RREADY_IN} <= 2'b00;
        if (w)
        begin
            `CHK("bresp", (a == IOCP_ADDR_STATUS) ? IOCP_RESP_SLVERR : IOCP_RESP_OKAY, BRESP_OUT)
            if (a != IOCP_ADDR_STATUS)
                mdl[a[3:2]] = ((mdl[a[3:2]] & ~be) | (d & be)) & wmask(a[3:2]);
        end
        else
        begin
            `CHK("rresp", IOCP_RESP_OKAY, RRESP_OUT)
            `CHK("rdata", {16'h0000, mdl[a[3:2]]}, RDATA_OUT)
        end
    endtask : bus

    task automatic check_outs();
        logic [15:0] io;
        logic [15:0] pw;
        logic [2:0] ck;
        logic wr_ok;
        @(negedge MCLK_IN);
        io = mdl[0];
        pw = mdl[1];
        ck = {io[13], io[8:7]};
        wr_ok = io[11] | !(MEM_IN.prog_space & MEM_IN.data_write);
        `CHK("pins", {io[10], !io[10], io[10], io[12], !io[12]}, PINS_OUT)
        `CHK("a15", MEM_IN.addr15 & !(io[14] & io[11]), ADDR_LINE_FIFTEEN_OUT)
        `CHK("pwrite", wr_ok, PROG_WRITE_ALLOW_OUT)
        `CHK("loop", io[9] ? SERIAL_DATA_OUT_IN : SERIAL_DATA_PIN_IN, SERIAL_DATA_IN_OUT)
        if (ck[2:1] == 2'b01) `CHK("cko", !ck[0], CLOCK_OUTPUT_OUT)
        else if (ck == 3'b100) `CHK("cko_raw", CLOCK_INPUT_IN, CLOCK_OUTPUT_OUT)
        `CHK("xtal", pw[15], CRYSTAL_OFF_OUT)
        `CHK("slow", pw[14], SLOW_CLOCK_OUT)
        `CHK("run", !pw[13], CORE_CLK_EN_OUT)
        `CHK("delay", io[3:0], DELAY_EN_OUT)
        `CHK("dis", {pw[7:4], pw[0]}, PERIPH_DISABLE_OUT)
        `CHK("wait", mdl[2], WAIT_STATES_OUT)
    endtask : check_outs

    task automatic do_reset(input logic ems, input logic irq1);
        @(posedge MCLK_IN);
        ARST_N_IN <= 1'b0;
        EXT_MEM_SEL_IN <= ems;
        IRQ_ONE_IN <= irq1;
        repeat (5) @(posedge MCLK_IN);
        ARST_N_IN <= 1'b1;
        repeat (4) @(posedge MCLK_IN);
        IRQ_ONE_IN <= 1'b0;
        mdl[0] = 16'h0000;
        mdl[1] = 16'h0000;
        mdl[2] = (ems && !irq1) ? IOCP_WAIT_ONES : IOCP_WAIT_ZEROS;
        check_outs();
        `CHK("rst_pins", 5'b01001, PINS_OUT)
        `CHK("rst_wait", mdl[2], WAIT_STATES_OUT)
        for (int i = 0; i < 3; i++)
            bus(1'b0, 4'(i * 4), 16'h0000, 2'b00, i);
    endtask : do_reset

    initial
    begin
        #100us;
        errors++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] r;
        logic [31:0] v;
        void'($urandom(32'hB33B));
        do_reset(1'b1, 1'b0);
        // Every clock output code, reserved ones included
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, IOCP_ADDR_IO_CFG, {2'b00, c[2], 4'h0, c[1:0], 7'h00}, 2'b11, 0);
            check_outs();
        end
        // Stop the clock, then try both wake lines with and without their enable
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, IOCP_ADDR_PWR_CTL, {2'b00, 1'b1, k[1] & !k[0], 1'b0, k[1] & k[0], 10'h000},
                2'b11, k);
            check_outs();
            @(posedge MCLK_IN);
            {IRQ_ONE_IN, IRQ_ZERO_IN} <= k[0] ? 2'b10 : 2'b01;
            @(posedge MCLK_IN);
            {IRQ_ONE_IN, IRQ_ZERO_IN} <= 2'b00;
            repeat (3) @(posedge MCLK_IN);
            if (k[1]) mdl[1][13] = 1'b0;
            check_outs();
            `CHK("wake", k[1], CORE_CLK_EN_OUT)
            bus(1'b0, IOCP_ADDR_PWR_CTL, 16'h0000, 2'b00, 0);
        end
        // Free clock follows only the ring oscillator while slow clock is on
        bus(1'b1, IOCP_ADDR_IO_CFG, 16'h0000, 2'b11, 0);
        bus(1'b1, IOCP_ADDR_PWR_CTL, 16'h4000, 2'b11, 0);
        for (int k = 0; k < 4; k++)
        begin
            @(negedge MCLK_IN);
            v[0] = CLOCK_OUTPUT_OUT;
            @(posedge MCLK_IN);
            {RING_OSC_TICK_IN, INSTR_CYCLE_IN} <= k[0] ? 2'b10 : 2'b01;
            @(posedge MCLK_IN);
            {RING_OSC_TICK_IN, INSTR_CYCLE_IN} <= 2'b00;
            @(negedge MCLK_IN);
            `CHK("slow_cko", v[0] ^ k[0], CLOCK_OUTPUT_OUT)
        end
        for (int t = 0; t < 120; t++)
        begin
            r = $urandom;
            v = $urandom;
            @(posedge MCLK_IN);
            MEM_IN <= {1'b1, r[0], 2'b11, r[2:1], r[3]};
            {SERIAL_DATA_OUT_IN, SERIAL_DATA_PIN_IN} <= r[7:4];
            {RING_OSC_TICK_IN, INSTR_CYCLE_IN, CLOCK_INPUT_IN} <= r[10:8];
            if (!r[11] && r[13:12] == 2'b11) r[13:12] = 2'b00;
            if (r[13:12] == 2'b01) v[15:0] = v[15:0] & IOCP_PWR_CTL_MASK;
            bus(r[11], {r[13:12], 2'b00}, v[15:0], r[15:14], int'(v[17:16]));
            check_outs();
        end
        // Reset in mid-run with two more pin combinations, both of which strap the wait register to zeros
        bus(1'b1, IOCP_ADDR_IO_CFG, 16'h7F8F, 2'b11, 0);
        do_reset(1'b1, 1'b1);
        do_reset(1'b0, 1'b0);
        give_verdict();
    end
endmodule : iocp_top_test

bind iocp_top iocp_top_monitor u_mon (
    .MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .AWVALID_IN(AWVALID_IN),
    .AWREADY_OUT(AWREADY_OUT), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
    .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
    .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT),
    .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .MEM_IN(MEM_IN),
    .ADDR_LINE_FIFTEEN_OUT(ADDR_LINE_FIFTEEN_OUT), .PINS_OUT(PINS_OUT)
);
